/* core/compat_io_pkg.sv */
`default_nettype none

package compat_io_pkg;

  // Data-space map seen by the core
  localparam int          IO_COUNT    = 64;
  localparam logic [15:0] GPR_LAST    = 16'h001F;
  localparam logic [15:0] IO_FIRST    = 16'h0020;
  localparam logic [15:0] IO_LAST     = 16'h005F;
  localparam logic [15:0] EXT_FIRST   = 16'h0060;
  localparam logic [15:0] EXT_LAST    = 16'h00FF;

  // Baud high bytes, I/O-space numbers
  localparam logic [5:0]  BAUD0_IO    = 6'h20;
  localparam logic [5:0]  BAUD1_IO    = 6'h3C;

  // Functions living in the extended region
  localparam logic [15:0] CLK_PRESC   = 16'h0061;
  localparam logic [15:0] PCMASK_LO   = 16'h006B;
  localparam logic [15:0] PCMASK_HI   = 16'h006C;
  localparam logic [15:0] T2ND_IRQ_LO = 16'h007C;
  localparam logic [15:0] T2ND_IRQ_HI = 16'h007D;
  localparam logic [15:0] T2ND_FIRST  = 16'h0080;
  localparam logic [15:0] T2ND_LAST   = 16'h008B;

  // APB register offsets (byte addresses)
  localparam logic [7:0]  OFF_STATUS  = 8'h00;
  localparam logic [7:0]  OFF_CTRL    = 8'h04;
  localparam logic [7:0]  OFF_FADDR   = 8'h08;
  localparam logic [7:0]  OFF_FCOUNT  = 8'h0C;

  // Status fields
  localparam int          ST_COMPAT   = 0;
  localparam int          ST_FAULT    = 1;
  localparam int          ST_LATCHED  = 2;

  // Control fields and reset value
  localparam int          CT_CAPTURE  = 0;
  localparam int          CT_BLOCK    = 1;
  localparam logic [1:0]  CTRL_RESET  = 2'h1;

  // Fault log reset value and count ceiling
  localparam logic [15:0] FADDR_RESET = 16'h0000;
  localparam logic [15:0] FCOUNT_MAX  = 16'hFFFF;

  // APB handshake states
  typedef enum logic [1:0] {
    APB_IDLE = 2'b01,
    APB_DONE = 2'b10
  } apb_state_t;

  // Nonvolatile setting capture states
  typedef enum logic [1:0] {
    NV_SAMPLE = 2'b01,
    NV_HELD   = 2'b10
  } nv_state_t;

endpackage

`default_nettype wire

/* core/io_space_decode.sv */
`timescale 1ns/100ps
`default_nettype none

module io_space_decode
  import compat_io_pkg::*;
(
  // Access from the core
  input  wire logic [15:0] addr,
  input  wire logic        io_insn,
  input  wire logic [5:0]  io_addr,
  input  wire logic        compat,
  // Decoded targets
  output logic      [15:0] eff_addr,
  output logic             gpr,
  output logic             io_reg,
  output logic             ext_reg,
  output logic             ext_rsvd,
  output logic             ram,
  output logic             baud0,
  output logic             baud1,
  output logic             timer2,
  output logic             pcint
);

  // I/O-instruction numbers map onto the ordinary window only
  assign eff_addr = io_insn ? (IO_FIRST + {10'h000, io_addr}) : addr;

  wire in_ext  = (eff_addr >= EXT_FIRST) && (eff_addr <= EXT_LAST);
  wire ext_on  = in_ext && !compat;
  wire is_t2   = (eff_addr >= T2ND_FIRST) && (eff_addr <= T2ND_LAST);
  wire is_t2i  = (eff_addr == T2ND_IRQ_LO) || (eff_addr == T2ND_IRQ_HI);
  wire is_pc   = (eff_addr == PCMASK_LO) || (eff_addr == PCMASK_HI);
  wire is_clkp = (eff_addr == CLK_PRESC);

  // Region selects
  assign gpr      = (eff_addr <= GPR_LAST);
  assign io_reg   = (eff_addr >= IO_FIRST) && (eff_addr <= IO_LAST);
  assign ext_reg  = ext_on;
  assign ram      = (eff_addr >= EXT_FIRST) && !ext_on;
  assign timer2   = ext_on && (is_t2 || is_t2i);
  assign pcint    = ext_on && is_pc;
  assign ext_rsvd = ext_on && !(is_t2 || is_t2i || is_pc || is_clkp);

  // Baud bytes sit at fixed spots in the ordinary window
  assign baud0 = (eff_addr == (IO_FIRST + {10'h000, BAUD0_IO}));
  assign baud1 = (eff_addr == (IO_FIRST + {10'h000, BAUD1_IO}));

endmodule

`default_nettype wire

/* core/legacy_compat_io_decode.sv */
// Operation
// - The extended register region at data addresses 0x60 to 0xFF is decoded besides the 64 ordinary I/O spots.
// - Extended registers answer only to load and store accesses, never to I/O instructions.
// - Every register of the predecessor keeps its address whatever the compatibility setting.
// - With the setting programmed no extended function is active and the range reaches plain RAM.
// - With the setting programmed the additional interrupt vectors are removed.
// - With the setting programmed the watchdog period changes without the timed unlock.
// - With the setting programmed the serial receivers use a single holding stage.
// - With the setting programmed pin-change interrupts are unavailable.
// - With the setting programmed only the first wide timer is usable and the second is unreachable.
// - Two separate baud high-byte registers exist, one per channel, at addresses fixed in both modes.
`timescale 1ns/100ps
`default_nettype none

module legacy_compat_io_decode
  import compat_io_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // Nonvolatile compatibility setting
  input  wire logic        LEGACY_COMPAT_FUSE,
  // Core access
  input  wire logic [15:0] CORE_ADDR,
  input  wire logic        CORE_RD,
  input  wire logic        CORE_WR,
  input  wire logic        CORE_IO_INSN,
  input  wire logic [5:0]  CORE_IO_ADDR,
  // Decoded access, one cycle after the request
  output logic      [15:0] SEL_ADDR,
  output logic             SEL_RD,
  output logic             SEL_WR,
  output logic             SEL_GPR,
  output logic             SEL_IO_REG,
  output logic             SEL_EXT_REG,
  output logic             SEL_RAM,
  output logic             SEL_SERIAL0_BAUD_HIGH,
  output logic             SEL_SERIAL1_BAUD_HIGH,
  output logic             SEL_SECOND_WIDE_TIMER,
  output logic             SEL_PIN_CHANGE,
  // Feature gates
  output logic             COMPAT_MODE,
  output logic             EXT_VECTORS_EN,
  output logic             WDOG_TIMED_SEQ_EN,
  output logic             RX_DOUBLE_BUF_EN,
  output logic             PIN_CHANGE_EN,
  output logic             SECOND_TIMER_EN,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR
);

  import compat_io_pkg::*;

  // Latched setting and its capture state
  logic       compat;
  logic       latched;
  nv_state_t  nv_state;

  // Software-visible state
  logic [1:0]  ctrl;
  logic        fault;
  logic [15:0] fault_addr;
  logic [15:0] fault_count;
  apb_state_t  apb_state;

  // Decoder results
  logic [15:0] eff_addr;
  logic        d_gpr;
  logic        d_io;
  logic        d_ext;
  logic        d_rsvd;
  logic        d_ram;
  logic        d_baud0;
  logic        d_baud1;
  logic        d_t2;
  logic        d_pc;

  // sampled once
  // The setting is taken one edge after reset release,
  // never under the asynchronous reset itself.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      nv_state <= NV_SAMPLE;
      compat   <= 1'b0;
      latched  <= 1'b0;
    end
    else
    begin
      unique case (nv_state)
        NV_SAMPLE:
        begin
          compat   <= LEGACY_COMPAT_FUSE;
          latched  <= 1'b1;
          nv_state <= NV_HELD;
        end
        NV_HELD:
        begin
          nv_state <= NV_HELD;
        end
        default:
        begin
          nv_state <= NV_SAMPLE;
        end
      endcase
    end
  end

  // Address decode shared by every access kind
  io_space_decode u_decode (
    .addr     (CORE_ADDR),
    .io_insn  (CORE_IO_INSN),
    .io_addr  (CORE_IO_ADDR),
    .compat   (compat),
    .eff_addr (eff_addr),
    .gpr      (d_gpr),
    .io_reg   (d_io),
    .ext_reg  (d_ext),
    .ext_rsvd (d_rsvd),
    .ram      (d_ram),
    .baud0    (d_baud0),
    .baud1    (d_baud1),
    .timer2   (d_t2),
    .pcint    (d_pc)
  );

  // Qualified access terms
  wire access   = CORE_RD || CORE_WR;
  wire ldst     = access && !CORE_IO_INSN;
  wire blocked  = ctrl[CT_BLOCK] && d_rsvd;
  wire fault_ev = ldst && d_rsvd && ctrl[CT_CAPTURE];

  // I/O numbers cannot reach past the ordinary window
  wire next_ext = ldst && d_ext && !blocked;

  // ordinary window decoded the same in both modes
  wire next_io  = access && d_io;

  // extended range falls through to RAM in compat mode
  wire next_ram = access && d_ram;

  // second wide timer only outside compat mode
  wire next_t2  = ldst && d_t2;

  // pin-change masks only outside compat mode
  wire next_pc  = ldst && d_pc;

  wire next_b0  = access && d_baud0;
  wire next_b1  = access && d_baud1;

  // Registered decode outputs
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      SEL_ADDR              <= 16'h0000;
      SEL_RD                <= 1'b0;
      SEL_WR                <= 1'b0;
      SEL_GPR               <= 1'b0;
      SEL_IO_REG            <= 1'b0;
      SEL_EXT_REG           <= 1'b0;
      SEL_RAM               <= 1'b0;
      SEL_SERIAL0_BAUD_HIGH <= 1'b0;
      SEL_SERIAL1_BAUD_HIGH <= 1'b0;
      SEL_SECOND_WIDE_TIMER <= 1'b0;
      SEL_PIN_CHANGE        <= 1'b0;
    end
    else
    begin
      SEL_ADDR              <= eff_addr;
      SEL_RD                <= CORE_RD;
      SEL_WR                <= CORE_WR;
      SEL_GPR               <= access && d_gpr;
      SEL_IO_REG            <= next_io;
      SEL_EXT_REG           <= next_ext;
      SEL_RAM               <= next_ram;
      SEL_SERIAL0_BAUD_HIGH <= next_b0;
      SEL_SERIAL1_BAUD_HIGH <= next_b1;
      SEL_SECOND_WIDE_TIMER <= next_t2 && !blocked;
      SEL_PIN_CHANGE        <= next_pc && !blocked;
    end
  end

  // Feature gates follow the held setting
  // Gates stay in the non-compat state until the
  // setting has been taken after reset.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      COMPAT_MODE       <= 1'b0;
      EXT_VECTORS_EN    <= 1'b1;
      WDOG_TIMED_SEQ_EN <= 1'b1;
      RX_DOUBLE_BUF_EN  <= 1'b1;
      PIN_CHANGE_EN     <= 1'b1;
      SECOND_TIMER_EN   <= 1'b1;
    end
    else
    begin
      COMPAT_MODE       <= compat;
      EXT_VECTORS_EN    <= !compat;
      WDOG_TIMED_SEQ_EN <= !compat;
      RX_DOUBLE_BUF_EN  <= !compat;
      PIN_CHANGE_EN     <= !compat;
      SECOND_TIMER_EN   <= !compat;
    end
  end

  // APB decode
  wire apb_go    = PSEL && PENABLE && (apb_state == APB_IDLE);
  wire apb_done  = PSEL && PENABLE && (apb_state == APB_DONE);
  wire hit_st    = (PADDR == OFF_STATUS);
  wire hit_ct    = (PADDR == OFF_CTRL);
  wire hit_fa    = (PADDR == OFF_FADDR);
  wire hit_fc    = (PADDR == OFF_FCOUNT);
  wire mapped    = hit_st || hit_ct || hit_fa || hit_fc;
  wire wr_commit = apb_done && PWRITE && mapped;
  wire clr_fault = wr_commit && hit_st && PWDATA[ST_FAULT];

  // Read mux
  wire [31:0] status_word = {29'h00000000, latched, fault, compat};
  wire [31:0] rd_word =
    hit_st ? status_word :
    hit_ct ? {30'h00000000, ctrl} :
    hit_fa ? {16'h0000, fault_addr} :
    hit_fc ? {16'h0000, fault_count} :
    32'h00000000;

  // APB handshake: one wait state, answer registered
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      apb_state <= APB_IDLE;
      PREADY    <= 1'b0;
      PRDATA    <= 32'h00000000;
      PSLVERR   <= 1'b0;
    end
    else
    begin
      unique case (apb_state)
        APB_IDLE:
        begin
          if (apb_go)
          begin
            apb_state <= APB_DONE;
            PREADY    <= 1'b1;
            PRDATA    <= PWRITE ? 32'h00000000 : rd_word;
            PSLVERR   <= !mapped;
          end
        end
        APB_DONE:
        begin
          apb_state <= APB_IDLE;
          PREADY    <= 1'b0;
          PRDATA    <= 32'h00000000;
          PSLVERR   <= 1'b0;
        end
        default:
        begin
          apb_state <= APB_IDLE;
          PREADY    <= 1'b0;
        end
      endcase
    end
  end

  // Control register, written at the completing edge
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      ctrl <= CTRL_RESET;
    end
    else if (wr_commit && hit_ct)
    begin
      ctrl <= PWDATA[1:0];
    end
  end

  // Fault flag: a new fault wins over a clear
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      fault <= 1'b0;
    end
    else if (fault_ev)
    begin
      fault <= 1'b1;
    end
    else if (clr_fault)
    begin
      fault <= 1'b0;
    end
  end

  // Fault log: last address, saturating count
  // Saturation keeps a flood of stray accesses
  // from wrapping back to a harmless-looking zero.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      fault_addr  <= FADDR_RESET;
      fault_count <= 16'h0000;
    end
    else if (fault_ev)
    begin
      fault_addr <= eff_addr;
      if (fault_count != FCOUNT_MAX)
      begin
        fault_count <= fault_count + 16'h0001;
      end
    end
    else if (wr_commit && hit_fc)
    begin
      fault_count <= 16'h0000;
    end
  end

endmodule

`default_nettype wire

/* test/compat_checker_assertions.sv */
`timescale 1ns/100ps
`default_nettype none

module compat_checker
  import compat_io_pkg::*;
(
  // Clock and reset
  input wire logic        CLK,
  input wire logic        RST,
  // Core side
  input wire logic [15:0] CORE_ADDR,
  input wire logic        CORE_RD,
  input wire logic        CORE_WR,
  input wire logic        CORE_IO_INSN,
  input wire logic [5:0]  CORE_IO_ADDR,
  // Decode and gates
  input wire logic [15:0] SEL_ADDR,
  input wire logic        SEL_IO_REG,
  input wire logic        SEL_EXT_REG,
  input wire logic        SEL_RAM,
  input wire logic        SEL_SERIAL1_BAUD_HIGH,
  input wire logic        SEL_SECOND_WIDE_TIMER,
  input wire logic        SEL_PIN_CHANGE,
  input wire logic        COMPAT_MODE,
  input wire logic        EXT_VECTORS_EN,
  input wire logic        WDOG_TIMED_SEQ_EN,
  input wire logic        RX_DOUBLE_BUF_EN,
  input wire logic        PIN_CHANGE_EN
);
  logic [1:0] cnt;
  logic       ls;
  logic       io;
  // Load/store versus I/O requests
  assign ls = (CORE_RD || CORE_WR) && !CORE_IO_INSN;
  assign io = (CORE_RD || CORE_WR) && CORE_IO_INSN;
  // Edges since reset; setting settles by the third
  always_ff @(posedge CLK or posedge RST)
    if (RST)
      cnt <= 2'h0;
    else if (cnt != 2'h3)
      cnt <= cnt + 2'h1;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  a_io_same_addr: assert property (io |=> SEL_IO_REG && SEL_ADDR == IO_FIRST + $past(CORE_IO_ADDR))
    else $error("io address moved");
  a_io_no_ext: assert property (io |=> !SEL_EXT_REG && !SEL_SECOND_WIDE_TIMER && !SEL_PIN_CHANGE)
    else $error("io reached extended");
  a_ext_decode: assert property (ls && cnt == 2'h3 && !COMPAT_MODE && CORE_ADDR == CLK_PRESC |=> SEL_EXT_REG)
    else $error("extended not decoded");
  a_ext_is_ram: assert property (ls && COMPAT_MODE && CORE_ADDR inside {[EXT_FIRST:EXT_LAST]}
    |=> SEL_RAM && !SEL_EXT_REG)
    else $error("compat range not ram");
  a_vector_gate: assert property (EXT_VECTORS_EN != COMPAT_MODE)
    else $error("vector gate wrong");
  a_wdog_gate: assert property (WDOG_TIMED_SEQ_EN != COMPAT_MODE)
    else $error("watchdog gate wrong");
  a_rx_gate: assert property ($rose(COMPAT_MODE) |-> !RX_DOUBLE_BUF_EN)
    else $error("rx buffer gate wrong");
  a_pin_gone: assert property (ls && COMPAT_MODE && CORE_ADDR == PCMASK_LO |=> !SEL_PIN_CHANGE && !PIN_CHANGE_EN)
    else $error("pin change reachable");
  a_timer_gone: assert property (ls && COMPAT_MODE && CORE_ADDR inside {[T2ND_FIRST:T2ND_LAST]}
    |=> !SEL_SECOND_WIDE_TIMER)
    else $error("second timer reachable");
  a_baud_fixed: assert property (ls && CORE_ADDR == 16'h005C |=> SEL_SERIAL1_BAUD_HIGH)
    else $error("baud high moved");
  a_compat_held: assert property (cnt == 2'h3 |=> $stable(COMPAT_MODE))
    else $error("setting changed");
  // Main scenarios
  c_compat_ram: cover property (ls && COMPAT_MODE);
  c_timer_hit: cover property (SEL_SECOND_WIDE_TIMER);
  c_io_access: cover property (io);
endmodule

bind legacy_compat_io_decode compat_checker compat_checker_i (.*);
`default_nettype wire

/* test/core_model.sv */
`timescale 1ns/100ps
`default_nettype none

module core_model
(
  // Clock
  input  wire logic        CLK,
  // Request lines
  output logic      [15:0] CORE_ADDR = 16'h0000,
  output logic             CORE_RD = 1'h0,
  output logic             CORE_WR = 1'h0,
  output logic             CORE_IO_INSN = 1'h0,
  output logic      [5:0]  CORE_IO_ADDR = 6'h00
);
  // One access for one edge, then released
  task automatic access(input logic [15:0] a, input logic io, input logic w);
    @(posedge CLK);
    // I/O numbers reach only ordinary space
    CORE_IO_INSN <= io;
    CORE_IO_ADDR <= 6'(a - 16'h0020);
    CORE_ADDR    <= io ? ~a : a;
    CORE_RD      <= !w;
    CORE_WR      <= w;
    @(posedge CLK);
    // Released lines show junk, not the last value
    CORE_ADDR    <= ~CORE_ADDR;
    CORE_IO_ADDR <= ~CORE_IO_ADDR;
    CORE_RD      <= 1'h0;
    CORE_WR      <= 1'h0;
  endtask
endmodule
`default_nettype wire

/* test/testbench.sv */
`timescale 1ns/100ps
`default_nettype none

module testbench;
  import compat_io_pkg::*;
  typedef struct packed {logic m; logic io; logic [15:0] a; logic [7:0] e;} row_t;
  logic        CLK = 1'h0, RST = 1'h1, LEGACY_COMPAT_FUSE = 1'h0, e;
  logic        CORE_RD, CORE_WR, CORE_IO_INSN, SEL_RD, SEL_WR, SEL_GPR, SEL_IO_REG, SEL_EXT_REG, SEL_RAM;
  logic        SEL_SERIAL0_BAUD_HIGH, SEL_SERIAL1_BAUD_HIGH, SEL_SECOND_WIDE_TIMER, SEL_PIN_CHANGE;
  logic        COMPAT_MODE, EXT_VECTORS_EN, WDOG_TIMED_SEQ_EN, RX_DOUBLE_BUF_EN, PIN_CHANGE_EN, SECOND_TIMER_EN;
  logic        PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0, PREADY, PSLVERR;
  logic [5:0]  CORE_IO_ADDR;
  logic [7:0]  PADDR = 8'h00;
  logic [15:0] CORE_ADDR, SEL_ADDR;
  logic [31:0] PWDATA = 32'h0, PRDATA, q;
  int          mismatches = 0, samples_checked = 0, cycles = 0;
  // Mode, I/O insn, address, {gpr,io,ext,ram,baud0,baud1,timer2,pinchg}
  row_t rows [16] = '{
    '{1'h1,1'h0,16'h0040,8'h48}, '{1'h1,1'h1,16'h005C,8'h44}, '{1'h1,1'h0,16'h0085,8'h10},
    '{1'h1,1'h0,16'h006B,8'h10}, '{1'h1,1'h0,16'h0061,8'h10}, '{1'h1,1'h0,16'h00FF,8'h10},
    '{1'h0,1'h0,16'h0010,8'h80}, '{1'h0,1'h1,16'h0040,8'h48}, '{1'h0,1'h0,16'h005C,8'h44},
    '{1'h0,1'h0,16'h0061,8'h20}, '{1'h0,1'h0,16'h006B,8'h21}, '{1'h0,1'h0,16'h0085,8'h22},
    '{1'h0,1'h0,16'h007D,8'h22}, '{1'h0,1'h0,16'h0100,8'h10}, '{1'h0,1'h0,16'h00FF,8'h20},
    '{1'h0,1'h0,16'h0070,8'h20}};

  legacy_compat_io_decode legacy_compat_io_decode_i (.*);
  core_model core_model_i (.*);

  always #25 CLK = ~CLK;
  // Hang guard, far above the planned run
  always @(posedge CLK)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      finish_test;
    end
  end

  task chk(input logic [31:0] g, input logic [31:0] x, input string s);
    samples_checked++;
    if (g !== x)
    begin
      mismatches++;
      $display("wrong value at %0t: %s got %h expected %h", $time, s, g, x);
    end
  endtask
  // Master waits for ready, then releases on the sampling edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1'h1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'h1;
    // Ready, data and error are taken at the rising edge that sees ready high
    do
      @(posedge CLK);
    while (PREADY !== 1'h1);
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'h0, a, 32'h0);
    chk(q, x, "register");
  endtask
  task do_reset(input logic m);
    @(posedge CLK);
    RST <= 1'h1;
    LEGACY_COMPAT_FUSE <= m;
    repeat (12) @(posedge CLK);
    chk(32'({SEL_GPR, SEL_EXT_REG, SEL_RAM, PREADY}), 32'h0, "in reset");
    RST <= 1'h0;
    repeat (3) @(posedge CLK);
    #1;
    chk(32'({COMPAT_MODE, EXT_VECTORS_EN, WDOG_TIMED_SEQ_EN, RX_DOUBLE_BUF_EN, PIN_CHANGE_EN,
        SECOND_TIMER_EN}), 32'({m, {5{!m}}}), "gates");
    rd(OFF_STATUS, 32'h4 | 32'(m));
    $display("reset test done");
  endtask
  task hit(input logic [15:0] a, input logic x);
    core_model_i.access(a, 1'h0, 1'h0);
    #1;
    chk(32'(SEL_EXT_REG), 32'(x), "extended");
  endtask
  task finish_test;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    for (int i = 0; i < 16; i++)
    begin
      if (rows[i].m !== LEGACY_COMPAT_FUSE)
        do_reset(rows[i].m);
      core_model_i.access(rows[i].a, rows[i].io, i[0]);
      #1;
      chk(32'({SEL_GPR, SEL_IO_REG, SEL_EXT_REG, SEL_RAM, SEL_SERIAL0_BAUD_HIGH, SEL_SERIAL1_BAUD_HIGH,
          SEL_SECOND_WIDE_TIMER, SEL_PIN_CHANGE}), 32'(rows[i].e), "select");
      chk(32'({SEL_ADDR, SEL_RD, SEL_WR}), 32'({rows[i].a, !i[0], i[0]}), "address");
      $display("row %0d done", i);
    end
    // Fault log after two reserved accesses, then clearing
    rd(OFF_FADDR, 32'h70);
    rd(OFF_FCOUNT, 32'h2);
    rd(OFF_STATUS, 32'h6);
    rd(OFF_CTRL, 32'h1);
    apb(1'h1, OFF_STATUS, 32'h2);
    rd(OFF_STATUS, 32'h4);
    apb(1'h1, OFF_FCOUNT, 32'h5);
    rd(OFF_FCOUNT, 32'h0);
    apb(1'h0, 8'h10, 32'h0);
    chk(32'(e), 32'h1, "unmapped error");
    chk(q, 32'h0, "unmapped data");
    $display("register test done");
    // Blocking reserved spots keeps defined ones; a blocked spot still counts
    apb(1'h1, OFF_CTRL, 32'h3);
    hit(16'h0070, 1'h0);
    hit(16'h0061, 1'h1);
    // Capture off: reserved access leaves the count alone
    apb(1'h1, OFF_CTRL, 32'h2);
    hit(16'h0070, 1'h0);
    rd(OFF_FCOUNT, 32'h1);
    // Fuse moves while running; mode must not follow
    @(posedge CLK);
    LEGACY_COMPAT_FUSE <= 1'h1;
    hit(16'h0061, 1'h1);
    chk(32'(COMPAT_MODE), 32'h0, "held");
    $display("held test done");
    finish_test;
  end
endmodule
`default_nettype wire
